// *** verilog/psb_pkg.sv ***
// shared constants and types of the pipelined synchronous sram bus block
package psb_pkg;

  localparam int PSB_ADDR_W = 21;
  localparam int PSB_DATA_W = 36;
  localparam int PSB_LANES = 4;
  localparam int PSB_LANE_W = 9;
  localparam int PSB_CNT_W = 2;
  localparam int PSB_BASE_W = PSB_ADDR_W - PSB_CNT_W;
  localparam int PSB_DEPTH = 32'h0020_0000;
  localparam int PSB_BUF_DEPTH = 2;
  localparam int PSB_BUF_CNT_W = 2;

  localparam logic PSB_ASSERTED_N = 1'b0;
  localparam logic PSB_NEGATED_N = 1'b1;
  localparam logic PSB_OFF = 1'b0;
  localparam logic [PSB_ADDR_W-1:0] PSB_ADDR_RST = 21'h00_0000;
  localparam logic [PSB_DATA_W-1:0] PSB_DATA_RST = 36'h0_0000_0000;
  localparam logic [PSB_LANES-1:0] PSB_LANES_NONE = 4'h0;
  localparam logic [PSB_LANES-1:0] PSB_LANES_ALL = 4'hf;
  localparam logic [PSB_LANES-1:0] PSB_LANES_N_RST = 4'hf;
  localparam logic [PSB_CNT_W-1:0] PSB_CNT_RST = 2'h0;
  localparam logic [PSB_CNT_W-1:0] PSB_CNT_STEP = 2'h1;
  localparam logic [PSB_BUF_CNT_W-1:0] PSB_BUF_CNT_RST = 2'h0;
  localparam logic [PSB_BUF_CNT_W-1:0] PSB_BUF_CNT_ONE = 2'h1;
  localparam logic [PSB_BUF_CNT_W-1:0] PSB_BUF_CNT_FULL = 2'h2;

  // access state, gray along idle -> active -> sleep
  typedef enum logic [1:0] {
    PSB_IDLE = 2'h0,
    PSB_ACTIVE = 2'h1,
    PSB_SLEEP = 2'h3
  } psb_state_t;

endpackage : psb_pkg

// *** verilog/psb_burst_counter.sv ***
// two-bit burst counter with interleaved and linear orderings
`timescale 1ns/1ps
module psb_burst_counter
  import psb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [PSB_CNT_W-1:0] seed_in,
  input wire logic advance_in,
  input wire logic linear_in,
  output logic [PSB_CNT_W-1:0] count_out
);

  logic [PSB_CNT_W-1:0] seed_reg;
  logic [PSB_CNT_W-1:0] step_reg;
  logic [PSB_CNT_W-1:0] seed_next;
  logic [PSB_CNT_W-1:0] step_next;

  function automatic logic [PSB_CNT_W-1:0] order(
    input logic [PSB_CNT_W-1:0] seed,
    input logic [PSB_CNT_W-1:0] step,
    input logic linear
  );
    order = linear ? PSB_CNT_W'(seed + step) : (seed ^ step);
  endfunction : order

  // seed from low address bits and step cleared on load, step bumped on advance, else hold
  assign seed_next = load_in ? seed_in : seed_reg;
  assign step_next = load_in ? PSB_CNT_RST :
                     advance_in ? PSB_CNT_W'(step_reg + PSB_CNT_STEP) :
                     step_reg;
  assign count_out = order(seed_next, step_next, linear_in);

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      seed_reg <= PSB_CNT_RST;
      step_reg <= PSB_CNT_RST;
    end
    else
    begin
      seed_reg <= seed_next;
      step_reg <= step_next;
    end
  end

endmodule : psb_burst_counter

// *** verilog/psb_pair_buffer.sv ***
// two-entry valid/ready buffer on the read data path
`timescale 1ns/1ps
module psb_pair_buffer
  import psb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [PSB_DATA_W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [PSB_DATA_W-1:0] out_data_out,
  output logic [PSB_BUF_CNT_W-1:0] count_out
);

  logic [PSB_DATA_W-1:0] slot_reg [PSB_BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [PSB_BUF_CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != PSB_BUF_CNT_FULL);
  assign out_valid_out = (count_reg != PSB_BUF_CNT_RST);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = slot_reg[rd_ptr_reg];
  assign count_out = count_reg;

  always_ff @(posedge clk_in)
  begin
    if (push)
      slot_reg[wr_ptr_reg] <= in_data_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr_reg <= PSB_OFF;
      rd_ptr_reg <= PSB_OFF;
      count_reg <= PSB_BUF_CNT_RST;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      if (push & ~pop)
        count_reg <= PSB_BUF_CNT_W'(count_reg + PSB_BUF_CNT_ONE);
      else if (pop & ~push)
        count_reg <= PSB_BUF_CNT_W'(count_reg - PSB_BUF_CNT_ONE);
    end
  end

endmodule : psb_pair_buffer

// *** verilog/psb_top.sv ***
// pipelined synchronous burst sram, bus side and array
`timescale 1ns/1ps
module psb_top
  import psb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [PSB_ADDR_W-1:0] address_in,
  input wire logic [PSB_DATA_W-1:0] data_in,
  output logic [PSB_DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic processor_address_strobe_n_in,
  input wire logic controller_address_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic primary_chip_select_n_in,
  input wire logic depth_select_high_in,
  input wire logic depth_select_low_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic lane_write_enable_n_in,
  input wire logic [PSB_LANES-1:0] byte_lane_select_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic linear_burst_in,
  input wire logic read_ready_in,
  output logic read_valid_out,
  output logic access_ready_out,
  output logic selected_out,
  output logic sleeping_out
);

  // registered copies of the synchronous bus
  logic [PSB_ADDR_W-1:0] addr_reg;
  logic [PSB_DATA_W-1:0] wdata_reg;
  logic proc_strobe_n_reg;
  logic ctrl_strobe_n_reg;
  logic advance_n_reg;
  logic cs_primary_n_reg;
  logic cs_high_reg;
  logic cs_low_n_reg;
  logic all_write_n_reg;
  logic lane_enable_n_reg;
  logic [PSB_LANES-1:0] lane_n_reg;
  logic linear_reg;

  logic sleep_meta_reg;
  logic sleep_sync_reg;

  psb_state_t state_reg;
  psb_state_t state_next;
  logic [PSB_BASE_W-1:0] base_reg;
  logic [PSB_DATA_W-1:0] array_q_reg;
  logic array_q_valid_reg;
  logic [PSB_DATA_W-1:0] mem [PSB_DEPTH];

  // decode of the registered bus
  logic cs_selected;
  logic proc_start;
  logic ctrl_start;
  logic strobe_seen;
  logic load;
  logic start_sel;
  logic start_desel;
  logic cont;
  logic room;
  logic [PSB_LANES-1:0] lane_mask;
  logic write_req;
  logic write_go;
  logic read_go;
  logic access_go;
  logic cnt_adv;
  logic [PSB_CNT_W-1:0] cnt_value;
  logic [PSB_BASE_W-1:0] access_base;
  logic [PSB_ADDR_W-1:0] access_addr;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [PSB_BUF_CNT_W-1:0] buf_count;
  logic [PSB_DATA_W-1:0] buf_data;
  logic buf_pop;
  logic [PSB_BUF_CNT_W:0] buf_load;

  function automatic logic [PSB_LANES-1:0] lanes_written(
    input logic all_write_n,
    input logic lane_enable_n,
    input logic [PSB_LANES-1:0] lane_n
  );
    if (all_write_n == PSB_ASSERTED_N)
      lanes_written = PSB_LANES_ALL;
    else if (lane_enable_n == PSB_ASSERTED_N)
      lanes_written = ~lane_n;
    else
      lanes_written = PSB_LANES_NONE;
  endfunction : lanes_written

  // capture the whole synchronous bus every edge
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      addr_reg <= PSB_ADDR_RST;
      wdata_reg <= PSB_DATA_RST;
      proc_strobe_n_reg <= PSB_NEGATED_N;
      ctrl_strobe_n_reg <= PSB_NEGATED_N;
      advance_n_reg <= PSB_NEGATED_N;
      cs_primary_n_reg <= PSB_NEGATED_N;
      cs_high_reg <= PSB_OFF;
      cs_low_n_reg <= PSB_NEGATED_N;
      all_write_n_reg <= PSB_NEGATED_N;
      lane_enable_n_reg <= PSB_NEGATED_N;
      lane_n_reg <= PSB_LANES_N_RST;
      linear_reg <= PSB_OFF;
    end
    else
    begin
      addr_reg <= address_in;
      wdata_reg <= data_in;
      proc_strobe_n_reg <= processor_address_strobe_n_in;
      ctrl_strobe_n_reg <= controller_address_strobe_n_in;
      advance_n_reg <= burst_advance_n_in;
      cs_primary_n_reg <= primary_chip_select_n_in;
      cs_high_reg <= depth_select_high_in;
      cs_low_n_reg <= depth_select_low_n_in;
      all_write_n_reg <= all_bytes_write_n_in;
      lane_enable_n_reg <= lane_write_enable_n_in;
      lane_n_reg <= byte_lane_select_n_in;
      linear_reg <= linear_burst_in;
    end
  end

  // sleep pin is asynchronous: synchronise before it gates accesses
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sleep_meta_reg <= PSB_OFF;
      sleep_sync_reg <= PSB_OFF;
    end
    else
    begin
      sleep_meta_reg <= sleep_request_in;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // select decode and strobe qualification
  assign cs_selected = (cs_primary_n_reg == PSB_ASSERTED_N) & cs_high_reg &
                       (cs_low_n_reg == PSB_ASSERTED_N);
  assign proc_start = (proc_strobe_n_reg == PSB_ASSERTED_N) &
                      (cs_primary_n_reg == PSB_ASSERTED_N);
  assign ctrl_start = (ctrl_strobe_n_reg == PSB_ASSERTED_N);
  assign strobe_seen = proc_start | ctrl_start;
  assign load = strobe_seen & room & ~sleep_sync_reg;
  assign start_sel = load & cs_selected;
  assign start_desel = load & ~cs_selected;
  assign cont = ~strobe_seen & (state_reg == PSB_ACTIVE) & ~sleep_sync_reg;

  // room for one more read word, counting the word in flight
  // a pop on the same edge frees its slot at once unless both slots are full
  assign buf_pop = buf_out_valid & read_ready_in;
  assign buf_load = {1'b0, buf_count} + {{PSB_BUF_CNT_W{1'b0}},
                    array_q_valid_reg} - {{PSB_BUF_CNT_W{1'b0}}, buf_pop};
  assign room = buf_in_ready &
                (buf_load < (PSB_BUF_CNT_W+1)'(PSB_BUF_DEPTH));

  // a processor-strobe start is a read; writes follow on later cycles
  assign lane_mask = lanes_written(all_write_n_reg, lane_enable_n_reg,
                                   lane_n_reg);
  assign write_req = (lane_mask != PSB_LANES_NONE) & ~(load & proc_start);
  assign access_go = start_sel | (cont & (write_req | room));
  assign write_go = access_go & write_req;
  assign read_go = access_go & ~write_req;
  // counter steps only on a real access with advance low
  assign cnt_adv = cont & access_go &
                   (advance_n_reg == PSB_ASSERTED_N);

  psb_burst_counter u_counter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(start_sel),
    .seed_in(addr_reg[PSB_CNT_W-1:0]),
    .advance_in(cnt_adv),
    .linear_in(linear_reg),
    .count_out(cnt_value)
  );

  assign access_base = start_sel ? addr_reg[PSB_ADDR_W-1:PSB_CNT_W] :
                       base_reg;
  assign access_addr = {access_base, cnt_value};

  // burst state: start, deselect and sleep
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PSB_IDLE:
      begin
        if (sleep_sync_reg)
          state_next = PSB_SLEEP;
        else if (start_sel)
          state_next = PSB_ACTIVE;
      end
      PSB_ACTIVE:
      begin
        if (sleep_sync_reg)
          state_next = PSB_SLEEP;
        else if (start_desel)
          state_next = PSB_IDLE;
      end
      PSB_SLEEP:
      begin
        if (~sleep_sync_reg)
          state_next = PSB_IDLE;
      end
      default:
        state_next = PSB_IDLE;
    endcase
  end

  // burst base held between accesses
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_reg <= PSB_IDLE;
      base_reg <= PSB_ADDR_RST[PSB_ADDR_W-1:PSB_CNT_W];
    end
    else
    begin
      state_reg <= state_next;
      base_reg <= access_base;
    end
  end

  // array: per-lane self-timed write, registered read
  always_ff @(posedge clk_in)
  begin
    if (write_go)
    begin
      for (int lane = 0; lane < PSB_LANES; lane++)
      begin
        if (lane_mask[lane])
          mem[access_addr][lane*PSB_LANE_W +: PSB_LANE_W] <=
            wdata_reg[lane*PSB_LANE_W +: PSB_LANE_W];
      end
    end
    if (read_go)
      array_q_reg <= mem[access_addr];
  end

  // flags the word in flight to the buffer
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      array_q_valid_reg <= PSB_OFF;
    else
      array_q_valid_reg <= read_go;
  end

  // output register stage, one word per clock after the first
  psb_pair_buffer u_out_buffer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(array_q_valid_reg),
    .in_ready_out(buf_in_ready),
    .in_data_in(array_q_reg),
    .out_valid_out(buf_out_valid),
    .out_ready_in(read_ready_in),
    .out_data_out(buf_data),
    .count_out(buf_count)
  );

  assign data_out = buf_data;
  assign read_valid_out = buf_out_valid;
  // drive gated straight from the pins, no clock involved
  assign data_oe_out = buf_out_valid &
                       (output_enable_n_in == PSB_ASSERTED_N) &
                       ~sleep_request_in;
  assign access_ready_out = room & ~sleep_sync_reg;
  // status straight from the state register
  assign selected_out = (state_reg == PSB_ACTIVE);
  assign sleeping_out = (state_reg == PSB_SLEEP);

endmodule : psb_top

// *** bench/psb_host_model.sv ***
// host side model: takes read words promptly or with long stalls
`timescale 1ns/1ps
module psb_host_model
  import psb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic stall_in,
  output logic read_ready_out
);
  logic [2:0] gap_reg;

  always_ff @(posedge clk_in)
  begin
    gap_reg <= reset_in ? 3'h0 : gap_reg + 3'h1;
    read_ready_out <= reset_in | !stall_in | (gap_reg == 3'h7);
  end
endmodule : psb_host_model

// *** bench/psb_checker.sv ***
// port assertions of the sram bus block
`timescale 1ns/1ps
module psb_checker
  import psb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [PSB_DATA_W-1:0] data_out,
  input wire logic data_oe_out,
  input wire logic processor_address_strobe_n_in,
  input wire logic controller_address_strobe_n_in,
  input wire logic primary_chip_select_n_in,
  input wire logic depth_select_high_in,
  input wire logic depth_select_low_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic lane_write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic read_ready_in,
  input wire logic read_valid_out,
  input wire logic access_ready_out,
  input wire logic selected_out,
  input wire logic sleeping_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  wire logic ld = !controller_address_strobe_n_in
    || (!processor_address_strobe_n_in && !primary_chip_select_n_in);
  wire logic on = !primary_chip_select_n_in && depth_select_high_in
    && !depth_select_low_n_in;
  wire logic idle = !read_valid_out && !selected_out;

  sequence s_take;
    access_ready_out && !sleeping_out;
  endsequence
  sequence s_read;
    idle && ld && on && all_bytes_write_n_in && lane_write_enable_n_in
      ##1 s_take;
  endsequence
  sequence s_write;
    idle && !controller_address_strobe_n_in && processor_address_strobe_n_in
      && on && !all_bytes_write_n_in ##1 s_take;
  endsequence

  a_read_latency: assert property (s_read |-> ##2 read_valid_out)
    else $error("first read word late");
  a_select_load: assert property
    (ld && on ##1 s_take |=> selected_out) else $error("no select");
  a_single_deselect: assert property
    (ld && !on ##1 s_take |=> !selected_out) else $error("no deselect");
  a_proc_ignored: assert property
    (!selected_out && !ld && !$past(ld) && !processor_address_strobe_n_in
      |=> ##1 !selected_out) else $error("strobe taken unselected");
  a_write_quiet: assert property (s_write |-> ##2 !read_valid_out)
    else $error("write gave read word");
  a_stall_holds: assert property
    (read_valid_out && !read_ready_in |=> read_valid_out && $stable(data_out))
    else $error("word lost in stall");
  a_drive_gate: assert property
    (data_oe_out == (read_valid_out && !output_enable_n_in
      && !sleep_request_in)) else $error("drive enable wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset_in |=> !read_valid_out && !selected_out && !sleeping_out)
    else $error("not quiet after reset");
endmodule : psb_checker

bind psb_top psb_checker u_chk (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .processor_address_strobe_n_in(processor_address_strobe_n_in),
  .controller_address_strobe_n_in(controller_address_strobe_n_in),
  .primary_chip_select_n_in(primary_chip_select_n_in),
  .depth_select_high_in(depth_select_high_in),
  .depth_select_low_n_in(depth_select_low_n_in),
  .all_bytes_write_n_in(all_bytes_write_n_in),
  .lane_write_enable_n_in(lane_write_enable_n_in),
  .output_enable_n_in(output_enable_n_in),
  .sleep_request_in(sleep_request_in),
  .read_ready_in(read_ready_in),
  .read_valid_out(read_valid_out),
  .access_ready_out(access_ready_out),
  .selected_out(selected_out),
  .sleeping_out(sleeping_out)
);

// *** bench/pipelined_sync_sram_bus_test.sv ***
// self-checking bench of the sram bus block
`timescale 1ns/1ps
module pipelined_sync_sram_bus_test;
  import psb_pkg::*;
  logic clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic [PSB_ADDR_W-1:0] address_in = PSB_ADDR_RST;
  logic [PSB_DATA_W-1:0] data_in = PSB_DATA_RST;
  logic processor_address_strobe_n_in = 1'h1;
  logic controller_address_strobe_n_in = 1'h1;
  logic burst_advance_n_in = 1'h1;
  logic primary_chip_select_n_in = 1'h0;
  logic depth_select_high_in = 1'h1;
  logic depth_select_low_n_in = 1'h0;
  logic all_bytes_write_n_in = 1'h1;
  logic lane_write_enable_n_in = 1'h1;
  logic [PSB_LANES-1:0] byte_lane_select_n_in = 4'hf;
  logic output_enable_n_in = 1'h0;
  logic sleep_request_in = 1'h0;
  logic linear_burst_in = 1'h0;
  logic stall = 1'h0;
  logic read_ready_in, read_valid_out, access_ready_out, data_oe_out;
  logic selected_out, sleeping_out;
  logic [PSB_DATA_W-1:0] data_out;
  logic [PSB_DATA_W-1:0] mm [logic [PSB_ADDR_W-1:0]];
  logic [PSB_DATA_W-1:0] got [$];
  logic [PSB_DATA_W-1:0] exq [$];
  logic [PSB_ADDR_W-1:0] base;
  int seed = 98;
  int fails = 0;
  int tests_run = 0;

  always #25 clk_in = ~clk_in;

  psb_top DUT (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .address_in(address_in),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_out(data_oe_out),
    .processor_address_strobe_n_in(processor_address_strobe_n_in),
    .controller_address_strobe_n_in(controller_address_strobe_n_in),
    .burst_advance_n_in(burst_advance_n_in),
    .primary_chip_select_n_in(primary_chip_select_n_in),
    .depth_select_high_in(depth_select_high_in),
    .depth_select_low_n_in(depth_select_low_n_in),
    .all_bytes_write_n_in(all_bytes_write_n_in),
    .lane_write_enable_n_in(lane_write_enable_n_in),
    .byte_lane_select_n_in(byte_lane_select_n_in),
    .output_enable_n_in(output_enable_n_in),
    .sleep_request_in(sleep_request_in),
    .linear_burst_in(linear_burst_in),
    .read_ready_in(read_ready_in),
    .read_valid_out(read_valid_out),
    .access_ready_out(access_ready_out),
    .selected_out(selected_out),
    .sleeping_out(sleeping_out)
  );
  psb_host_model host (.clk_in, .reset_in, .stall_in(stall),
    .read_ready_out(read_ready_in));

  always @(posedge clk_in)
    if (read_valid_out === 1'h1 && read_ready_in === 1'h1)
      got.push_back(data_out);

  task automatic check(input logic [PSB_DATA_W-1:0] seen, want);
    tests_run++;
    if (seen !== want)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wrap_up;
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // a bounded wait that ran out ends the run
  task automatic need(input logic ok);
    check(PSB_DATA_W'(ok), PSB_DATA_W'(1'h1));
    if (ok !== 1'h1)
      wrap_up();
  endtask : need

  function automatic logic [PSB_DATA_W-1:0] rnd36;
    return PSB_DATA_W'({$random(seed), $random(seed)});
  endfunction : rnd36

  function automatic logic [1:0] ord(input logic [1:0] s, k, input logic lin);
    return lin ? s + k : s ^ k;
  endfunction : ord

  task automatic drv(input logic ps, cs, burst_advance_n, input logic [2:0] sel,
    input logic gw = 1'h1, lw = 1'h1, input logic [3:0] ln = 4'hf,
    input logic [PSB_ADDR_W-1:0] a = PSB_ADDR_RST,
    input logic [PSB_DATA_W-1:0] d = PSB_DATA_RST);
    processor_address_strobe_n_in <= ps;
    controller_address_strobe_n_in <= cs;
    burst_advance_n_in <= burst_advance_n;
    primary_chip_select_n_in <= sel[2];
    depth_select_high_in <= sel[1];
    depth_select_low_n_in <= sel[0];
    all_bytes_write_n_in <= gw;
    lane_write_enable_n_in <= lw;
    byte_lane_select_n_in <= ln;
    address_in <= a;
    data_in <= d;
    output_enable_n_in <= 1'($random(seed));
    @(posedge clk_in);
  endtask : drv

  // one select off, strobe held until the block has room to take it
  task automatic desel;
    logic [2:0] sel;
    sel = 3'h2 ^ (3'h1 << ($unsigned($random(seed)) % 3));
    drv(1'h1, 1'h0, 1'h1, sel);
    @(posedge clk_in);
    for (int i = 0; i < 30 && selected_out !== 1'h0; i++)
      @(posedge clk_in);
    need(selected_out === 1'h0);
    drv(1'h1, 1'h1, 1'h1, 3'h2);
  endtask : desel

  task automatic wr(input logic [PSB_ADDR_W-1:0] a, input logic gw, lw,
    input logic [3:0] ln, input logic [PSB_DATA_W-1:0] d);
    for (int j = 0; j < PSB_LANES; j++)
      if (!gw || (!lw && !ln[j]))
        mm[a][j*PSB_LANE_W +: PSB_LANE_W] = d[j*PSB_LANE_W +: PSB_LANE_W];
    drv(1'h1, 1'h0, 1'h1, 3'h2, gw, lw, ln, a, d);
    desel();
  endtask : wr

  task automatic rd(input logic ps, lin, input logic [2:0] burst_advance_n,
    input logic [PSB_ADDR_W-1:0] a);
    logic [1:0] off;
    off = 2'h0;
    got = {};
    exq = {mm[a]};
    linear_burst_in <= lin;
    drv(ps, ~ps, 1'h1, 3'h2, 1'h1, 1'h1, 4'hf, a);
    for (int i = 0; i < 3; i++)
    begin
      // address pins are ignored on continuations
      drv(1'h1, 1'h1, burst_advance_n[i], 3'h2, 1'h1, 1'h1, 4'hf,
        PSB_ADDR_W'($random(seed)));
      off = off + 2'(!burst_advance_n[i]);
      exq.push_back(mm[{a[PSB_ADDR_W-1:2], ord(a[1:0], off, lin)}]);
    end
    desel();
    if (stall)
    begin
      // drive must drop at once while a word stands
      sleep_request_in <= 1'h1;
      output_enable_n_in <= 1'h0;
      @(posedge clk_in);
      check(PSB_DATA_W'(data_oe_out), PSB_DATA_RST);
      sleep_request_in <= 1'h0;
    end
    for (int i = 0; i < 30 && read_valid_out !== 1'h0; i++)
      @(posedge clk_in);
    @(posedge clk_in);
    need(read_valid_out === 1'h0);
    if (!stall)
      check(PSB_DATA_W'(got.size()), PSB_DATA_W'(exq.size()));
    foreach (got[i])
      check(got[i], exq[i]);
  endtask : rd

  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'h0;
    @(posedge clk_in);
    // processor strobe while the primary select is off
    drv(1'h0, 1'h1, 1'h1, 3'h6);
    drv(1'h1, 1'h1, 1'h1, 3'h2);
    repeat (3) @(posedge clk_in);
    check(PSB_DATA_W'(read_valid_out | selected_out), PSB_DATA_RST);
    for (int i = 0; i < 8; i++)
    begin
      base = PSB_ADDR_W'($random(seed));
      for (int k = 0; k < 4; k++)
        wr({base[PSB_ADDR_W-1:2], 2'(k)}, 1'h0, 1'h1, 4'hf, rnd36());
      wr({base[PSB_ADDR_W-1:2], 2'(i)}, 1'h1, 1'h0, 4'($random(seed)),
        rnd36());
      wr({base[PSB_ADDR_W-1:2], 2'(i + 1)}, 1'h0, 1'($random(seed)),
        4'($random(seed)), rnd36());
      stall <= (i == 7);
      rd(1'(i >> 1), 1'(i), (i == 7) ? 3'h0 : 3'($random(seed)), base);
    end
    stall <= 1'h0;
    sleep_request_in <= 1'h1;
    for (int i = 0; i < 10 && sleeping_out !== 1'h1; i++)
      @(posedge clk_in);
    need(sleeping_out === 1'h1);
    check(PSB_DATA_W'(access_ready_out), PSB_DATA_RST);
    check(PSB_DATA_W'(data_oe_out), PSB_DATA_RST);
    sleep_request_in <= 1'h0;
    for (int i = 0; i < 10 && sleeping_out !== 1'h0; i++)
      @(posedge clk_in);
    need(sleeping_out === 1'h0);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    wrap_up();
  end
endmodule : pipelined_sync_sram_bus_test
